/* File: bench/eect_mem_model.sv */
// Behavioural model of the serial memory target on the far side of the bus.
// Assumes SCL and SDA wire levels from the bench; SDA is pulled up outside.
`timescale 1ns/1ns
module eect_mem_model #(
    parameter int COMMIT_NS = 30000
) (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       wp,
    input  wire logic [2:0] strap,
    output logic            dev_oe
);
    logic [7:0]  mem [0:8191];
    logic [7:0]  pend_d [0:31];
    logic [12:0] pend_a [0:31];
    logic [12:0] ptr;
    logic [7:0]  shreg;
    logic [4:0]  addr_hi;
    int          phase;
    int          bitn;
    int          n_pend;
    time         busy_until;

    initial begin
        for (int i = 0; i < 8192; i++) mem[i] = 8'(i) ^ 8'h5a;
        ptr = 13'h0;
        phase = 0;
        bitn = 0;
        n_pend = 0;
        busy_until = 0;
        dev_oe = 1'b0;
    end

    // Start, ignored while committing
    always @(negedge sda) if (scl === 1'b1 && $time >= busy_until) begin
        phase = 1;
        bitn = 0;
        n_pend = 0;
        dev_oe = 1'b0;
    end

    // Stop, commits pending data unless protected
    always @(posedge sda) if (scl === 1'b1) begin
        if (n_pend > 0 && wp !== 1'b1) begin
            for (int k = 0; k < n_pend && k < 32; k++) mem[pend_a[k]] = pend_d[k];
            busy_until = $time + COMMIT_NS;
        end
        phase = 0;
        n_pend = 0;
        dev_oe = 1'b0;
    end

    // Sample on rise
    always @(posedge scl) if (phase != 0) begin
        if (bitn < 8 && phase != 5) shreg = {shreg[6:0], sda};
        if (bitn == 8 && phase == 5 && sda !== 1'b0) phase = 0;
        bitn++;
    end

    // Update on fall
    always @(negedge scl) if (phase != 0) begin
        if (bitn == 8) begin
            dev_oe = (phase != 5);
            case (phase)
                1: if (shreg[7:4] == 4'ha && shreg[3:1] == strap) begin
                    phase = shreg[0] ? 5 : 2;
                end else begin
                    phase = 0;
                    dev_oe = 1'b0;
                end
                2: begin
                    addr_hi = shreg[4:0];
                    phase = 3;
                end
                3: begin
                    ptr = {addr_hi, shreg};
                    phase = 4;
                end
                4: begin
                    pend_a[n_pend % 32] = ptr;
                    pend_d[n_pend % 32] = shreg;
                    n_pend++;
                    ptr = {ptr[12:5], ptr[4:0] + 5'h1};
                end
                default: ;
            endcase
        end else if (bitn == 9) begin
            bitn = 0;
            dev_oe = 1'b0;
            if (phase == 5) begin
                shreg = mem[ptr];
                ptr = ptr + 13'h1;
                dev_oe = !shreg[7];
            end
        end else if (phase == 5) begin
            dev_oe = !shreg[7 - bitn];
        end
    end
endmodule : eect_mem_model

/* File: bench/two_wire_serial_eeprom_target_tb.sv */
// Self-checking bench for the two-wire memory controller against a target model.
// Assumes the controller package and a pulled-up SDA wire built here.
`timescale 1ns/1ns
module two_wire_serial_eeprom_target_tb;
    import eect_pkg::*;
    logic       core_clk = 1'b0;
    logic       rstn = 1'b0;
    logic       cmd_valid = 1'b0;
    eect_op_t   cmd_op = OP_WRITE;
    logic [2:0] cmd_chip_sel = 3'h0;
    logic [12:0] cmd_addr = 13'h0;
    logic [7:0] cmd_len = 8'h0;
    logic [7:0] wr_data = 8'h0;
    logic       wr_valid = 1'b0;
    logic       wp = 1'b0;
    logic       sda_hold = 1'b0;
    logic       cmd_ready, wr_ready, rd_valid, done, error, scl_out, sda_out, sda_oe, dev_oe;
    logic [7:0] rd_data;
    wire logic  sda_line;
    logic [7:0] wbuf [0:31];
    logic [7:0] rbuf [0:255];
    logic [7:0] ref_mem [0:8191];
    logic [12:0] exp_ptr = 13'h0;
    logic [2:0] strap;
    int         seed = 32'h2f62;
    int         n_rd, wi, n_mismatch = 0, n_checks = 0;

    // Open-drain wire: pulled up, low when either side pulls or the bench jams it
    assign sda_line = (sda_oe === 1'b1 ? sda_out : 1'b1) && dev_oe !== 1'b1 && !sda_hold;
    always #4 core_clk = ~core_clk;

    eect_controller #(.COMMIT_LIMIT(20000)) uut (
        .core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_chip_sel(cmd_chip_sel), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
        .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
        .rd_valid(rd_valid), .done(done), .error(error), .scl_out(scl_out),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe));
    eect_mem_model dev (.scl(scl_out), .sda(sda_line), .wp(wp), .strap(strap), .dev_oe(dev_oe));

    function automatic logic [12:0] waddr(input logic [12:0] a, input int k);
        return {a[12:5], a[4:0] + 5'(k)};
    endfunction : waddr

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic run_cmd(input eect_op_t op, input logic [2:0] cs, input logic [12:0] a,
                           input logic [7:0] n, output logic e);
        n_rd = 0;
        wi = 0;
        e = 1'b1;
        @(negedge core_clk);
        while (cmd_ready !== 1'b1) @(negedge core_clk);
        cmd_op = op;
        cmd_chip_sel = cs;
        cmd_addr = a;
        cmd_len = n;
        cmd_valid = 1'b1;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        for (int t = 0; t < 40000; t++) begin
            if (rd_valid === 1'b1) begin
                rbuf[n_rd] = rd_data;
                n_rd++;
            end
            if (wr_valid && wr_ready !== 1'b1) begin
                wr_valid = 1'b0;
                wi++;
            end else if (wr_ready === 1'b1 && !wr_valid && $random(seed) % 4 == 0) begin
                wr_data = wbuf[wi];
                wr_valid = 1'b1;
            end
            if (done === 1'b1) begin
                e = error;
                return;
            end
            @(negedge core_clk);
        end
        chk("command completion", 1'b0, 1'b1);
        tally_and_finish;
    endtask : run_cmd

    task automatic do_write(input logic [12:0] a, input int n);
        logic e;
        for (int i = 0; i < n; i++) wbuf[i] = 8'($random(seed));
        run_cmd(OP_WRITE, strap, a, 8'(n), e);
        chk("write error", e, 1'b0);
        chk("commit finished", $time >= dev.busy_until, 1'b1);
        for (int i = 0; i < n; i++) if (!wp) ref_mem[waddr(a, i)] = wbuf[i];
        exp_ptr = waddr(a, n);
    endtask : do_write

    task automatic do_read(input eect_op_t op, input logic [12:0] a, input int n);
        logic e;
        run_cmd(op, strap, a, 8'(n), e);
        chk("read error", e, 1'b0);
        chk("read count", n_rd, n);
        if (op == OP_READ_RAND) exp_ptr = a;
        for (int i = 0; i < n; i++) begin
            chk("read byte", rbuf[i], ref_mem[exp_ptr]);
            exp_ptr = exp_ptr + 13'h1;
        end
    endtask : do_read

    task tally_and_finish;
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (105000) @(posedge core_clk);
        n_mismatch++;
        tally_and_finish;
    end

    initial begin
        logic        e;
        logic [12:0] a;
        for (int i = 0; i < 8192; i++) ref_mem[i] = 8'(i) ^ 8'h5a;
        strap = 3'($random(seed));
        repeat (10) @(negedge core_clk);
        rstn = 1'b1;
        run_cmd(OP_WRITE, strap, 13'h0, 8'h0, e);
        chk("zero length refused", e, 1'b1);
        run_cmd(OP_WRITE, strap, 13'h0, 8'h21, e);
        chk("long page refused", e, 1'b1);
        run_cmd(OP_READ_CUR, strap ^ 3'h5, 13'h0, 8'h1, e);
        chk("other chip silent", e, 1'b1);
        do_read(OP_READ_CUR, 13'h0, 1);
        a = {8'($random(seed)), 5'h1e};
        do_write(a, 3);
        chk("page wrap byte", dev.mem[{a[12:5], 5'h00}], ref_mem[{a[12:5], 5'h00}]);
        do_read(OP_READ_RAND, a, 2);
        do_read(OP_READ_RAND, 13'h1fff, 2);
        do_read(OP_READ_CUR, 13'h0, 1);
        wp = 1'b1;
        a = 13'($random(seed));
        do_write(a, 1);
        chk("protected byte", dev.mem[a], ref_mem[a]);
        wp = 1'b0;
        sda_hold = 1'b1;
        run_cmd(OP_RECOVER, strap, 13'h0, 8'h1, e);
        chk("stuck bus recovery", e, 1'b1);
        sda_hold = 1'b0;
        run_cmd(OP_RECOVER, strap, 13'h0, 8'h1, e);
        chk("recovery error", e, 1'b0);
        tally_and_finish;
    end
endmodule : two_wire_serial_eeprom_target_tb

/* File: core/eect_controller.sv */
// Bus controller that drives a two-wire serial memory through SCL and SDA.
// Assumes one pull-up on SDA; SCL is driven push-pull, derived from core_clk.
//
// How it works
// - Start: SDA falls while SCL high
// - Stop: SDA rises while SCL high
// - SDA changes only while SCL is low
// - Device word opens with fixed family bits
// - Stop after data starts target write
// - Page write holds at most 32 bytes
// - Poll with device word until acked or COMMIT_LIMIT cycles pass
// - Last read byte gets no ack
// - Random read: dummy write, restart, read
// - Ack continues sequential read, nack ends
// - Recovery clocks up to nine until SDA releases, then start and stop; error if it never releases
`timescale 1ns/1ns
module eect_controller #(
    parameter int COMMIT_LIMIT = eect_pkg::COMMIT_CYC
) (
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    input  wire logic                      cmd_valid,
    output logic                           cmd_ready,
    input  wire eect_pkg::eect_op_t        cmd_op,
    input  wire logic [2:0]                cmd_chip_sel,
    input  wire logic [eect_pkg::ADDR_W-1:0] cmd_addr,
    input  wire logic [7:0]                cmd_len,
    input  wire logic [7:0]                wr_data,
    input  wire logic                      wr_valid,
    output logic                           wr_ready,
    output logic [7:0]                     rd_data,
    output logic                           rd_valid,
    output logic                           done,
    output logic                           error,
    output logic                           scl_out,
    input  wire logic                      sda_in,
    output logic                           sda_out,
    output logic                           sda_oe
);
    import eect_pkg::*;

    eect_state_t              state;
    eect_step_t               step;
    eect_op_t                 op;
    logic [1:0]               phase;
    logic [3:0]               bit_cnt;
    logic [3:0]               rec_cnt;
    logic [7:0]               shift;
    logic [7:0]               remain;
    logic [2:0]               chip;
    logic [ADDR_W-1:0]        addr;
    logic                     scl;
    logic                     sda_rel;
    logic                     acked;
    logic                     err;
    logic [31:0]              poll_cnt;
    logic [7:0]               q_cnt;
    logic                     tick;
    logic                     sda_meta;
    logic                     sda_s;
    logic                     rw_bit;

    assign cmd_ready = (state == S_IDLE);
    assign wr_ready  = (state == S_FETCH);
    assign scl_out   = scl;
    assign sda_out   = 1'b0;
    assign sda_oe    = ~sda_rel;
    assign tick      = (q_cnt == 8'h00);
    assign rw_bit    = (step == P_RDEV) || (step == P_DEV && op == OP_READ_CUR);

    // Pin synchroniser
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sda_meta <= 1'b1;
            sda_s    <= 1'b1;
        end else begin
            sda_meta <= sda_in;
            sda_s    <= sda_meta;
        end
    end

    // Quarter-bit timer
    always_ff @(posedge core_clk) begin
        if (!rstn || tick) begin
            q_cnt <= 8'(QTR_CYC - 1);
        end else begin
            q_cnt <= q_cnt - 8'h01;
        end
    end

    // Write-cycle poll timer
    always_ff @(posedge core_clk) begin
        if (!rstn || step != P_POLL) begin
            poll_cnt <= 32'h0;
        end else if (poll_cnt < 32'(COMMIT_LIMIT)) begin
            poll_cnt <= poll_cnt + 32'h1;
        end
    end

    // Bus sequencer
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state    <= S_IDLE;
            step     <= P_DEV;
            op       <= OP_WRITE;
            phase    <= 2'h0;
            bit_cnt  <= 4'h0;
            rec_cnt  <= 4'h0;
            shift    <= 8'h00;
            remain   <= 8'h00;
            chip     <= 3'h0;
            addr     <= '0;
            scl      <= 1'b1;
            sda_rel  <= 1'b1;
            acked    <= 1'b0;
            err      <= 1'b0;
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
            done     <= 1'b0;
            error    <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            done     <= 1'b0;
            error    <= 1'b0;
            if (state == S_IDLE) begin
                scl     <= 1'b1;
                sda_rel <= 1'b1;
                phase   <= 2'h0;
                bit_cnt <= 4'h0;
                rec_cnt <= 4'h0;
                err     <= 1'b0;
                if (cmd_valid) begin
                    op     <= cmd_op;
                    chip   <= cmd_chip_sel;
                    addr   <= cmd_addr;
                    remain <= cmd_len;
                    step   <= P_DEV;
                    if (cmd_op == OP_RECOVER) begin
                        state <= S_RECOVER;
                    end else if (cmd_len == 8'h00 ||
                                 (cmd_op == OP_WRITE && cmd_len > PAGE_BYTES)) begin
                        done  <= 1'b1;
                        error <= 1'b1;
                    end else begin
                        state <= S_START;
                    end
                end
            end else if (state == S_FETCH) begin
                if (wr_valid) begin
                    shift  <= wr_data;
                    remain <= remain - 8'h01;
                    state  <= S_TX;
                end
            end else if (tick) begin
                phase <= phase + 2'h1;
                case (state)
                    S_START: begin
                        case (phase)
                            2'h0: scl <= 1'b0;
                            2'h1: sda_rel <= 1'b1;
                            2'h2: scl <= 1'b1;
                            default: begin
                                sda_rel <= 1'b0;
                                bit_cnt <= 4'h0;
                                if (op == OP_RECOVER) begin
                                    state <= S_STOP;
                                end else begin
                                    shift <= {DEV_FAMILY, chip, rw_bit};
                                    state <= S_TX;
                                end
                            end
                        endcase
                    end
                    S_TX: begin
                        case (phase)
                            2'h0: scl <= 1'b0;
                            2'h1: sda_rel <= (bit_cnt == ACK_BIT) ? 1'b1 : shift[7];
                            2'h2: scl <= 1'b1;
                            default: begin
                                if (bit_cnt != ACK_BIT) begin
                                    shift   <= {shift[6:0], 1'b0};
                                    bit_cnt <= bit_cnt + 4'h1;
                                end else begin
                                    bit_cnt <= 4'h0;
                                    acked   <= ~sda_s;
                                    if (sda_s) begin
                                        err   <= (step != P_POLL);
                                        state <= S_STOP;
                                    end else begin
                                        case (step)
                                            P_DEV: begin
                                                if (op == OP_READ_CUR) begin
                                                    step  <= P_DATA;
                                                    state <= S_RX;
                                                end else begin
                                                    step  <= P_AH;
                                                    shift <= 8'({addr[ADDR_W-1:8]});
                                                end
                                            end
                                            P_AH: begin
                                                step  <= P_AL;
                                                shift <= addr[7:0];
                                            end
                                            P_AL: begin
                                                if (op == OP_READ_RAND) begin
                                                    step  <= P_RDEV;
                                                    state <= S_START;
                                                end else begin
                                                    step  <= P_DATA;
                                                    state <= S_FETCH;
                                                end
                                            end
                                            P_DATA: begin
                                                state <= (remain == 8'h00) ? S_STOP
                                                                           : S_FETCH;
                                            end
                                            P_RDEV: begin
                                                step  <= P_DATA;
                                                state <= S_RX;
                                            end
                                            default: state <= S_STOP;
                                        endcase
                                    end
                                end
                            end
                        endcase
                    end
                    S_RX: begin
                        case (phase)
                            2'h0: scl <= 1'b0;
                            2'h1: begin
                                sda_rel <= (bit_cnt == ACK_BIT) ? (remain == 8'h01)
                                                                : 1'b1;
                            end
                            2'h2: scl <= 1'b1;
                            default: begin
                                if (bit_cnt != ACK_BIT) begin
                                    shift   <= {shift[6:0], sda_s};
                                    bit_cnt <= bit_cnt + 4'h1;
                                    if (bit_cnt == 4'h7) begin
                                        rd_data  <= {shift[6:0], sda_s};
                                        rd_valid <= 1'b1;
                                    end
                                end else begin
                                    bit_cnt <= 4'h0;
                                    remain  <= remain - 8'h01;
                                    if (remain == 8'h01) begin
                                        state <= S_STOP;
                                    end
                                end
                            end
                        endcase
                    end
                    S_STOP: begin
                        case (phase)
                            2'h0: scl <= 1'b0;
                            2'h1: sda_rel <= 1'b0;
                            2'h2: scl <= 1'b1;
                            default: begin
                                sda_rel <= 1'b1;
                                if (op == OP_WRITE && step == P_DATA && !err) begin
                                    step  <= P_POLL;
                                    state <= S_START;
                                end else if (step == P_POLL && !acked &&
                                             poll_cnt < 32'(COMMIT_LIMIT)) begin
                                    state <= S_START;
                                end else begin
                                    done  <= 1'b1;
                                    error <= err || (step == P_POLL && !acked);
                                    state <= S_IDLE;
                                end
                            end
                        endcase
                    end
                    S_RECOVER: begin
                        case (phase)
                            2'h0: scl <= 1'b0;
                            2'h1: sda_rel <= 1'b1;
                            2'h2: scl <= 1'b1;
                            default: begin
                                if (sda_s) begin
                                    state <= S_START;
                                end else if (rec_cnt == RECOVER_CLOCKS - 4'h1) begin
                                    done  <= 1'b1;
                                    error <= 1'b1;
                                    state <= S_IDLE;
                                end else begin
                                    rec_cnt <= rec_cnt + 4'h1;
                                end
                            end
                        endcase
                    end
                    default: state <= S_IDLE;
                endcase
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_sda_fell_high;
        $fell(sda_rel) && scl;
    endsequence
    sequence s_sda_rose_high;
        $rose(sda_rel) && scl;
    endsequence

    property p_start_edge;
        s_sda_fell_high |-> $past(state) == S_START;
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("SDA fell outside start");

    property p_stop_edge;
        s_sda_rose_high |-> $past(state) == S_STOP;
    endproperty
    a_stop_edge: assert property (p_stop_edge) else $error("SDA rose outside stop");

    property p_data_low;
        $changed(sda_rel) && $past(state) inside {S_TX, S_RX} |-> !scl;
    endproperty
    a_data_low: assert property (p_data_low) else $error("data moved with SCL high");

    property p_dev_word;
        state == S_TX && bit_cnt == 4'h0 && step inside {P_DEV, P_RDEV, P_POLL}
            |-> shift[7:4] == DEV_FAMILY;
    endproperty
    a_dev_word: assert property (p_dev_word) else $error("bad family bits");

    property p_addr_high;
        state == S_TX && step == P_AH && bit_cnt == 4'h0 |-> shift[7:5] == 3'h0;
    endproperty
    a_addr_high: assert property (p_addr_high) else $error("unused address bits set");

    property p_page_len;
        state == S_FETCH |-> remain >= 8'h01 && remain <= PAGE_BYTES;
    endproperty
    a_page_len: assert property (p_page_len) else $error("page write too long");

    property p_write_stop;
        $past(state) == S_TX && state == S_STOP && step == P_DATA && op == OP_WRITE
            |-> remain == 8'h00 || err;
    endproperty
    a_write_stop: assert property (p_write_stop) else $error("early stop");

    property p_last_nack;
        state == S_RX && bit_cnt == ACK_BIT && phase == 2'h2 |-> sda_rel == (remain == 8'h01);
    endproperty
    a_last_nack: assert property (p_last_nack) else $error("wrong read ack");

    property p_rand_read;
        state == S_TX && step == P_RDEV |-> op == OP_READ_RAND;
    endproperty
    a_rand_read: assert property (p_rand_read) else $error("restart outside random read");

    property p_recover;
        state == S_RECOVER |-> rec_cnt < RECOVER_CLOCKS && sda_rel;
    endproperty
    a_recover: assert property (p_recover) else $error("recovery overran");

    property p_scl_steady;
        $changed(scl) && state != S_IDLE |=> $stable(scl) [*8];
    endproperty
    a_scl_steady: assert property (p_scl_steady) else $error("SCL too fast");
endmodule : eect_controller

/* File: core/eect_pkg.sv */
// Constants and types for the two-wire serial memory controller.
// Assumes a 125 MHz core clock and one memory target on an open-drain bus.
package eect_pkg;
    localparam int CORE_CLK_MHZ   = 125;
    // Quarter of one bus bit period, giving about 400 kHz on the clock pin
    localparam int QUARTER_NS     = 625;
    localparam int QTR_CYC        = (QUARTER_NS * CORE_CLK_MHZ + 999) / 1000;
    // nonvolatile_commit_time, longest self-timed write
    localparam int COMMIT_TIME_MS = 5;
    localparam int COMMIT_CYC     = COMMIT_TIME_MS * CORE_CLK_MHZ * 1000;
    localparam logic [3:0] DEV_FAMILY     = 4'ha;
    localparam int         ADDR_W         = 13;
    localparam logic [7:0] PAGE_BYTES     = 8'h20;
    localparam logic [3:0] RECOVER_CLOCKS = 4'h9;
    localparam logic [3:0] ACK_BIT        = 4'h8;

    typedef enum logic [1:0] {OP_WRITE, OP_READ_CUR, OP_READ_RAND, OP_RECOVER} eect_op_t;
    typedef enum logic [2:0] {
        S_IDLE, S_START, S_TX, S_FETCH, S_RX, S_STOP, S_RECOVER
    } eect_state_t;
    typedef enum logic [2:0] {P_DEV, P_AH, P_AL, P_DATA, P_RDEV, P_POLL} eect_step_t;
endpackage : eect_pkg
